// ===== rtl/lbt_defs.svh
// Constants of the latching bus transceiver: widths, offsets, fields, resets
`ifndef LBT_DEFS_SVH
`define LBT_DEFS_SVH

`define LBT_WIDE_W 8
`define LBT_ADDR_W 8
`define LBT_DATA_W 32
`define LBT_LOG_W 9
`define LBT_LOG_DEPTH 32

`define LBT_REG_CTRL 8'h00
`define LBT_REG_STATUS 8'h04
`define LBT_REG_LOG 8'h08
`define LBT_REG_STORED 8'h0C

`define LBT_CTRL_LOG_AB 0
`define LBT_CTRL_LOG_BA 1
`define LBT_CTRL_RST 2'h0

`define LBT_STAT_EMPTY 0
`define LBT_STAT_FULL 1
`define LBT_STAT_DROP 2
`define LBT_STAT_COUNT_LSB 8
`define LBT_STAT_COUNT_MSB 15

`define LBT_LOG_VALID 31
`define LBT_LOG_DIR 8
`define LBT_STORED_BA_LSB 8
`define LBT_STORED_BA_MSB 15

`endif

// ===== rtl/lbt_pkg.sv
// Types shared by the latching bus transceiver design files
`include "lbt_defs.svh"

package lbt_pkg;

   // Controls shared by all eight wide-path bit channels
   typedef struct packed {
      logic oe_n;
      logic dir;
      logic le;
      logic clk_ab;
      logic clk_ba;
   } lbt_wide_ctl_t;

   // One single-bit four-wire channel as seen at its inputs
   typedef struct packed {
      logic bit_in;
      logic drive_en;
      logic fb_en_n;
      logic line_in;
   } lbt_single_t;

   typedef struct packed {
      logic [`LBT_WIDE_W-1:0] stor_ab;
      logic [`LBT_WIDE_W-1:0] stor_ba;
      logic clk_ab_prev;
      logic clk_ba_prev;
      logic [`LBT_WIDE_W-1:0] card_out;
      logic [`LBT_WIDE_W-1:0] bp_out;
      logic card_oe;
      logic bp_oe;
      logic [1:0] line_out;
      logic [1:0] line_oe;
      logic [1:0] mon_out;
      logic [1:0] mon_oe;
      logic [1:0] ctrl;
      logic drop;
      logic log_ready;
      logic [`LBT_DATA_W-1:0] rdata;
   } lbt_state_t;

endpackage

// ===== rtl/lbt_fifo.sv
// Capture log FIFO with registered head word
`timescale 1ns/1ps
`default_nettype none

module lbt_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 32
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data,
   output logic [$clog2(DEPTH):0] o_count
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic [W-1:0] head;
   } lbt_fifo_state_t;

   lbt_fifo_state_t s_q;
   lbt_fifo_state_t s_d;
   logic [W-1:0] mem [DEPTH];
   logic wr;
   logic rd;

   always_comb begin
      s_d = s_q;
      wr = i_wr_valid && (s_q.count != FULL_CNT);
      rd = i_rd_ready && (s_q.count != '0);
      if (wr) begin
         s_d.wptr = s_q.wptr + 1'b1;
      end
      if (rd) begin
         s_d.rptr = s_q.rptr + 1'b1;
      end
      s_d.count = s_q.count + (AW+1)'(wr) - (AW+1)'(rd);
      // Bypass so a word written into an emptying FIFO is visible at once
      if (wr && (s_q.wptr == s_d.rptr)) begin
         s_d.head = i_wr_data;
      end else begin
         s_d.head = mem[s_d.rptr];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Storage has no reset; only the pointers define what is valid
   always_ff @(posedge i_core_clk) begin
      if (wr) begin
         mem[s_q.wptr] <= i_wr_data;
      end
   end

   assign o_wr_ready = (s_q.count != FULL_CNT);
   assign o_rd_valid = (s_q.count != '0);
   assign o_rd_data = s_q.head;
   assign o_count = s_q.count;

endmodule
`default_nettype wire

// ===== rtl/lbt_transceiver.sv
// Latching bus transceiver: wide path, two single-bit channels, capture log
//
// What this block does
// - All paths pass data without inversion
// - Line enable high drives line, low releases
// - Feedback enable low drives monitor, else off
// - Monitor output shows current backplane line level
// - Both enables: drive line and monitor together
// - Wide enable high floats both wide ports
// - Transparent enable high passes data straight through
// - Latched, steady clock: destination holds stored data
// - Latched: rising direction clock captures source data
// - Reverse direction identical, own clock and store
// - Latch entry keeps passed level if clock high
// - Eight identical channels share all wide controls
`timescale 1ns/1ps
`default_nettype none
`include "lbt_defs.svh"

module lbt_transceiver #(
   parameter int LOG_DEPTH = `LBT_LOG_DEPTH
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_wide_oe_n,
   input wire logic i_direction,
   input wire logic i_transparent_enable,
   input wire logic i_card_to_backplane_clock,
   input wire logic i_backplane_to_card_clock,
   input wire logic [`LBT_WIDE_W-1:0] i_card_side_port,
   output logic [`LBT_WIDE_W-1:0] o_card_side_port,
   output logic o_card_side_port_oe,
   input wire logic [`LBT_WIDE_W-1:0] i_backplane_side_port,
   output logic [`LBT_WIDE_W-1:0] o_backplane_side_port,
   output logic o_backplane_side_port_oe,
   input wire logic i_single_bit_in_first,
   input wire logic i_single_bit_in_second,
   input wire logic i_line_drive_enable_first,
   input wire logic i_line_drive_enable_second,
   input wire logic i_feedback_enable_n_first,
   input wire logic i_feedback_enable_n_second,
   input wire logic i_backplane_line_first,
   input wire logic i_backplane_line_second,
   output logic o_backplane_line_first,
   output logic o_backplane_line_first_oe,
   output logic o_backplane_line_second,
   output logic o_backplane_line_second_oe,
   output logic o_monitor_out_first,
   output logic o_monitor_out_first_oe,
   output logic o_monitor_out_second,
   output logic o_monitor_out_second_oe,
   input wire logic [`LBT_ADDR_W-1:0] i_reg_addr,
   input wire logic [`LBT_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [`LBT_DATA_W-1:0] o_reg_rdata,
   output logic o_log_ready
);

   // -------------------------------------------------------------------
   // Input grouping
   // -------------------------------------------------------------------
   lbt_pkg::lbt_wide_ctl_t ctl;
   lbt_pkg::lbt_single_t [1:0] sb;
   lbt_pkg::lbt_state_t s_q;
   lbt_pkg::lbt_state_t s_d;

   assign ctl = '{oe_n: i_wide_oe_n, dir: i_direction,
                  le: i_transparent_enable,
                  clk_ab: i_card_to_backplane_clock,
                  clk_ba: i_backplane_to_card_clock};
   assign sb[0] = '{bit_in: i_single_bit_in_first,
                    drive_en: i_line_drive_enable_first,
                    fb_en_n: i_feedback_enable_n_first,
                    line_in: i_backplane_line_first};
   assign sb[1] = '{bit_in: i_single_bit_in_second,
                    drive_en: i_line_drive_enable_second,
                    fb_en_n: i_feedback_enable_n_second,
                    line_in: i_backplane_line_second};

   // -------------------------------------------------------------------
   // Capture log
   // -------------------------------------------------------------------
   logic push;
   logic pop;
   logic [`LBT_LOG_W-1:0] log_word;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [`LBT_LOG_W-1:0] fifo_head;
   logic [$clog2(LOG_DEPTH):0] fifo_count;

   lbt_fifo #(
      .W(`LBT_LOG_W),
      .DEPTH(LOG_DEPTH)
   ) lbt_fifo_inst (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_wr_valid(push),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(log_word),
      .o_rd_valid(fifo_rd_valid),
      .i_rd_ready(pop),
      .o_rd_data(fifo_head),
      .o_count(fifo_count)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   logic ab_edge;
   logic ba_edge;
   logic cap_ab;
   logic cap_ba;
   logic drop_set;
   logic drop_clr;
   logic [`LBT_DATA_W-1:0] stat_word;

   always_comb begin
      s_d = s_q;
      push = 1'b0;
      pop = 1'b0;
      log_word = '0;
      drop_set = 1'b0;
      drop_clr = 1'b0;
      stat_word = '0;
      ab_edge = ctl.clk_ab && !s_q.clk_ab_prev;
      ba_edge = ctl.clk_ba && !s_q.clk_ba_prev;
      s_d.clk_ab_prev = ctl.clk_ab;
      s_d.clk_ba_prev = ctl.clk_ba;

      // While transparent with the clock high the store follows the
      // source, so a falling enable leaves the last passed level in it;
      // with the clock low the older stored word survives.
      if (ab_edge || (ctl.le && ctl.clk_ab)) begin
         s_d.stor_ab = i_card_side_port;
      end
      if (ba_edge || (ctl.le && ctl.clk_ba)) begin
         s_d.stor_ba = i_backplane_side_port;
      end

      // Otherwise the store holds whatever the source does
      s_d.bp_out = ctl.le ? i_card_side_port : s_d.stor_ab;
      s_d.card_out = ctl.le ? i_backplane_side_port : s_d.stor_ba;
      s_d.bp_oe = !ctl.oe_n && ctl.dir;
      s_d.card_oe = !ctl.oe_n && !ctl.dir;

      for (int i = 0; i < 2; i++) begin
         s_d.line_out[i] = sb[i].bit_in;
         s_d.line_oe[i] = sb[i].drive_en;
         s_d.mon_out[i] = sb[i].line_in;
         s_d.mon_oe[i] = !sb[i].fb_en_n;
      end

      // Only clocked captures are logged; a transparent pass has no
      // single moment worth recording.
      cap_ab = ab_edge && !ctl.le && s_q.ctrl[`LBT_CTRL_LOG_AB];
      cap_ba = ba_edge && !ctl.le && s_q.ctrl[`LBT_CTRL_LOG_BA];
      if (cap_ab) begin
         push = 1'b1;
         log_word = {1'b0, i_card_side_port};
      end else if (cap_ba) begin
         push = 1'b1;
         log_word = {1'b1, i_backplane_side_port};
      end
      // The pins cannot stall, so a full log loses the word and says so
      drop_set = (cap_ab && cap_ba) || (push && !fifo_wr_ready);
      s_d.log_ready = fifo_wr_ready;

      if (i_reg_wr && (i_reg_addr == `LBT_REG_CTRL)) begin
         s_d.ctrl = i_reg_wdata[1:0];
      end
      if (i_reg_wr && (i_reg_addr == `LBT_REG_STATUS)) begin
         drop_clr = i_reg_wdata[`LBT_STAT_DROP];
      end
      // A drop in the clearing cycle stays recorded
      s_d.drop = (s_q.drop && !drop_clr) || drop_set;

      stat_word[`LBT_STAT_EMPTY] = !fifo_rd_valid;
      stat_word[`LBT_STAT_FULL] = !fifo_wr_ready;
      stat_word[`LBT_STAT_DROP] = s_q.drop;
      stat_word[`LBT_STAT_COUNT_MSB:`LBT_STAT_COUNT_LSB] = 8'(fifo_count);

      s_d.rdata = '0;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `LBT_REG_CTRL: begin
               s_d.rdata = {30'h0, s_q.ctrl};
            end
            `LBT_REG_STATUS: begin
               s_d.rdata = stat_word;
            end
            `LBT_REG_LOG: begin
               pop = fifo_rd_valid;
               s_d.rdata[`LBT_LOG_VALID] = fifo_rd_valid;
               s_d.rdata[`LBT_LOG_W-1:0] = fifo_rd_valid ? fifo_head : '0;
            end
            `LBT_REG_STORED: begin
               s_d.rdata[`LBT_WIDE_W-1:0] = s_q.stor_ab;
               s_d.rdata[`LBT_STORED_BA_MSB:`LBT_STORED_BA_LSB] = s_q.stor_ba;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         // Data stores keep running through reset: no defined content
         s_q <= s_d;
         s_q.card_out <= '0;
         s_q.bp_out <= '0;
         s_q.card_oe <= 1'b0;
         s_q.bp_oe <= 1'b0;
         s_q.line_out <= '0;
         s_q.line_oe <= '0;
         s_q.mon_out <= '0;
         s_q.mon_oe <= '0;
         s_q.ctrl <= `LBT_CTRL_RST;
         s_q.drop <= 1'b0;
         s_q.log_ready <= 1'b0;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_card_side_port = s_q.card_out;
   assign o_card_side_port_oe = s_q.card_oe;
   assign o_backplane_side_port = s_q.bp_out;
   assign o_backplane_side_port_oe = s_q.bp_oe;
   assign o_backplane_line_first = s_q.line_out[0];
   assign o_backplane_line_first_oe = s_q.line_oe[0];
   assign o_backplane_line_second = s_q.line_out[1];
   assign o_backplane_line_second_oe = s_q.line_oe[1];
   assign o_monitor_out_first = s_q.mon_out[0];
   assign o_monitor_out_first_oe = s_q.mon_oe[0];
   assign o_monitor_out_second = s_q.mon_out[1];
   assign o_monitor_out_second_oe = s_q.mon_oe[1];
   assign o_reg_rdata = s_q.rdata;
   assign o_log_ready = s_q.log_ready;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   a_wide_isolate: assert property (
      i_wide_oe_n |=> !o_card_side_port_oe && !o_backplane_side_port_oe)
      else $error("wide port driven while disabled");

   a_single_driver: assert property (
      !(o_card_side_port_oe && o_backplane_side_port_oe))
      else $error("both wide ports driven");

   a_dir_select: assert property (
      !i_wide_oe_n |=> (o_backplane_side_port_oe == $past(i_direction))
                       && (o_card_side_port_oe == !$past(i_direction)))
      else $error("wrong wide port driven for direction");

   a_ab_transparent: assert property (
      i_transparent_enable |=> o_backplane_side_port ==
                               $past(i_card_side_port))
      else $error("transparent card to backplane mismatch");

   a_ba_transparent: assert property (
      i_transparent_enable |=> o_card_side_port ==
                               $past(i_backplane_side_port))
      else $error("transparent backplane to card mismatch");

   a_ab_hold: assert property (
      (!i_transparent_enable && !$past(i_transparent_enable)
       && $stable(i_card_to_backplane_clock))
      |=> $stable(o_backplane_side_port))
      else $error("latched output changed without clock edge");

   a_ab_capture: assert property (
      (!i_transparent_enable && $rose(i_card_to_backplane_clock))
      |=> o_backplane_side_port == $past(i_card_side_port))
      else $error("rising clock did not capture card data");

   a_latch_entry: assert property (
      (i_transparent_enable && i_card_to_backplane_clock)
      ##1 (!i_transparent_enable && i_card_to_backplane_clock)
      |=> o_backplane_side_port == $past(i_card_side_port, 2))
      else $error("latch entry lost last passed level");

   a_line_drive: assert property (
      i_line_drive_enable_first |=> o_backplane_line_first_oe
         && (o_backplane_line_first == $past(i_single_bit_in_first)))
      else $error("backplane line not driven from input");

   a_line_release: assert property (
      !i_line_drive_enable_second |=> !o_backplane_line_second_oe)
      else $error("backplane line not released");

   a_mon_disable: assert property (
      i_feedback_enable_n_second |=> !o_monitor_out_second_oe)
      else $error("monitor output driven while disabled");

   a_mon_level: assert property (
      !i_feedback_enable_n_first |=> o_monitor_out_first_oe
         && (o_monitor_out_first == $past(i_backplane_line_first)))
      else $error("monitor output does not follow line");

   a_line_drive_two: assert property (
      i_line_drive_enable_second |=> o_backplane_line_second_oe
         && (o_backplane_line_second == $past(i_single_bit_in_second)))
      else $error("second backplane line not driven from input");

   a_ba_hold: assert property (
      (!i_transparent_enable && !$past(i_transparent_enable)
       && $stable(i_backplane_to_card_clock))
      |=> $stable(o_card_side_port))
      else $error("latched card output changed without clock edge");

   a_ba_capture: assert property (
      (!i_transparent_enable && $rose(i_backplane_to_card_clock))
      |=> o_card_side_port == $past(i_backplane_side_port))
      else $error("rising clock did not capture backplane data");

   a_ba_latch_entry: assert property (
      (i_transparent_enable && i_backplane_to_card_clock)
      ##1 (!i_transparent_enable && i_backplane_to_card_clock)
      |=> o_card_side_port == $past(i_backplane_side_port, 2))
      else $error("reverse latch entry lost last passed level");

   c_latch_entry: cover property (
      i_transparent_enable ##1 !i_transparent_enable);
   c_clock_capture: cover property (
      !i_transparent_enable && $rose(i_card_to_backplane_clock));
   c_drive_feedback: cover property (
      i_line_drive_enable_first && !i_feedback_enable_n_first);
   c_log_full: cover property (!o_log_ready);
   c_reverse_capture: cover property (
      !i_transparent_enable && $rose(i_backplane_to_card_clock));

endmodule
`default_nettype wire

// ===== test/lbt_far_side.sv
// Far-side model: terminated backplane lines and wide backplane port
`timescale 1ns/1ps
`default_nettype none

module lbt_far_side (
   input wire logic [1:0] i_line_val,
   input wire logic [1:0] i_line_oe,
   input wire logic [1:0] i_far_en,
   input wire logic [1:0] i_far_val,
   input wire logic [7:0] i_bp_val,
   input wire logic i_bp_oe,
   input wire logic i_far_bp_en,
   input wire logic [7:0] i_far_bp,
   output logic [1:0] o_line,
   output logic [7:0] o_bp
);
   // Terminated lines float high once every driver lets go
   // Far side only drives while the block releases, so no contention
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         o_line[i] = i_line_oe[i] ? i_line_val[i] :
            (i_far_en[i] ? i_far_val[i] : 1'h1);
      end
      o_bp = i_bp_oe ? i_bp_val : (i_far_bp_en ? i_far_bp : 8'hFF);
   end
endmodule

`default_nettype wire

// ===== test/lbt_transceiver_test.sv
// Self-checking testbench of the latching bus transceiver
`timescale 1ns/1ps
`default_nettype none
`include "lbt_defs.svh"

module lbt_transceiver_test;
   logic clk = 1'h0, rst_b = 1'h0, oe_n = 1'h1, dir = 1'h1, le = 1'h1;
   logic cab = 1'h0, cba = 1'h0;
   logic [7:0] card = 8'h00, far_bp = 8'h00, addr = 8'h00;
   logic [7:0] card_w, bp_w, o_card, o_bp;
   logic [1:0] sin = 2'h0, den = 2'h0, fbn = 2'h3, far_en = 2'h3;
   logic [1:0] far_val = 2'h0;
   logic [1:0] line, lo, loe, mo, moe;
   logic far_bp_en = 1'h1, wr = 1'h0, rd = 1'h0, card_oe, bp_oe, log_rdy;
   logic [31:0] wdata = 32'h0, rdata;
   int err_total = 0, total_checks = 0;

   always #5 clk = ~clk;
   assign card_w = card_oe ? o_card : card;

   lbt_transceiver #(.LOG_DEPTH(4)) lbt_transceiver_inst (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_wide_oe_n(oe_n),
      .i_direction(dir), .i_transparent_enable(le),
      .i_card_to_backplane_clock(cab), .i_backplane_to_card_clock(cba),
      .i_card_side_port(card_w), .o_card_side_port(o_card),
      .o_card_side_port_oe(card_oe), .i_backplane_side_port(bp_w),
      .o_backplane_side_port(o_bp), .o_backplane_side_port_oe(bp_oe),
      .i_single_bit_in_first(sin[0]), .i_single_bit_in_second(sin[1]),
      .i_line_drive_enable_first(den[0]),
      .i_line_drive_enable_second(den[1]),
      .i_feedback_enable_n_first(fbn[0]),
      .i_feedback_enable_n_second(fbn[1]),
      .i_backplane_line_first(line[0]), .i_backplane_line_second(line[1]),
      .o_backplane_line_first(lo[0]), .o_backplane_line_first_oe(loe[0]),
      .o_backplane_line_second(lo[1]), .o_backplane_line_second_oe(loe[1]),
      .o_monitor_out_first(mo[0]), .o_monitor_out_first_oe(moe[0]),
      .o_monitor_out_second(mo[1]), .o_monitor_out_second_oe(moe[1]),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .o_log_ready(log_rdy));

   lbt_far_side lbt_far_side_inst (
      .i_line_val(lo), .i_line_oe(loe), .i_far_en(far_en),
      .i_far_val(far_val), .i_bp_val(o_bp), .i_bp_oe(bp_oe),
      .i_far_bp_en(far_bp_en), .i_far_bp(far_bp), .o_line(line),
      .o_bp(bp_w));

   // ----------------------------------------------------------------
   // Compare and bus tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_val(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Outputs are registered: inputs of edge N show just after edge N
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk_val(nm, e, rdata);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_wide_oe();
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         oe_n <= k[1];
         dir <= k[0];
         settle(2);
         chk_bit("bp_oe", !k[1] && k[0], bp_oe);
         chk_bit("card_oe", !k[1] && !k[0], card_oe);
      end
   endtask

   task automatic t_single();
      logic lv;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         den <= {2{k[0]}};
         // Equal enables act as one direction control
         fbn <= {2{k[1]}};
         sin <= {~k[2], k[2]};
         far_val <= {k[2], ~k[2]};
         settle(2);
         for (int i = 0; i < 2; i++) begin
            lv = k[0] ? sin[i] : far_val[i];
            chk_bit("line_oe", k[0], loe[i]);
            if (k[0]) chk_bit("line", sin[i], lo[i]);
            chk_bit("mon_oe", !k[1], moe[i]);
            if (!k[1]) chk_bit("monitor", lv, mo[i]);
         end
      end
   endtask

   task automatic t_transparent();
      logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
      for (int d = 0; d < 2; d++) begin
         foreach (pat[p]) begin
            @(posedge clk);
            oe_n <= 1'h0;
            le <= 1'h1;
            dir <= d[0];
            card <= pat[p];
            far_bp <= ~pat[p];
            settle(2);
            if (d != 0) chk_val("bp_port", pat[p], o_bp);
            else chk_val("card_port", 8'(~pat[p]), o_card);
         end
      end
   endtask

   task automatic t_latch();
      @(posedge clk);
      dir <= 1'h1;
      cab <= 1'h1;
      card <= 8'h96;
      settle(1);
      @(posedge clk);
      le <= 1'h0;
      settle(1);
      @(posedge clk);
      card <= 8'h11;
      settle(2);
      chk_val("latch_hi", 8'h96, o_bp);
      @(posedge clk);
      le <= 1'h1;
      cab <= 1'h0;
      card <= 8'h22;
      settle(2);
      @(posedge clk);
      le <= 1'h0;
      settle(1);
      @(posedge clk);
      card <= 8'h33;
      settle(2);
      // Clock low at latch entry keeps the older stored value
      chk_val("latch_lo", 8'h96, o_bp);
   endtask

   task automatic t_clocked();
      @(posedge clk);
      card <= 8'h3C;
      settle(1);
      @(posedge clk);
      cab <= 1'h1;
      settle(2);
      chk_val("clocked", 8'h3C, o_bp);
      @(posedge clk);
      card <= 8'hC3;
      settle(2);
      chk_val("hold_hi", 8'h3C, o_bp);
      @(posedge clk);
      cab <= 1'h0;
      settle(2);
      chk_val("hold_lo", 8'h3C, o_bp);
      @(posedge clk);
      dir <= 1'h0;
      far_bp <= 8'h69;
      settle(2);
      @(posedge clk);
      cba <= 1'h1;
      settle(2);
      chk_val("clocked_ba", 8'h69, o_card);
      @(posedge clk);
      far_bp <= 8'h5C;
      cba <= 1'h0;
      cab <= 1'h1;
      settle(2);
      chk_val("ba_own_clk", 8'h69, o_card);
   endtask

   task automatic t_log();
      rd_chk("ctrl_rst", `LBT_REG_CTRL, 32'h0);
      rd_chk("unmapped", 8'h10, 32'h0);
      reg_wr(8'h14, 32'hFFFF_FFFF);
      rd_chk("status", `LBT_REG_STATUS, 32'h1);
      reg_wr(`LBT_REG_CTRL, 32'h1);
      rd_chk("ctrl", `LBT_REG_CTRL, 32'h1);
      @(posedge clk);
      dir <= 1'h1;
      // Five captures into four places: the last one is dropped
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         cab <= 1'h0;
         card <= 8'h40 + 8'(k);
         settle(1);
         @(posedge clk);
         cab <= 1'h1;
         settle(1);
      end
      settle(1);
      chk_bit("log_ready", 1'h0, log_rdy);
      rd_chk("status_full", `LBT_REG_STATUS, 32'h0000_0406);
      for (int k = 0; k < 4; k++) begin
         rd_chk("log_ab", `LBT_REG_LOG, 32'h8000_0040 + 32'(k));
      end
      rd_chk("log_empty", `LBT_REG_LOG, 32'h0);
      rd_chk("status_drop", `LBT_REG_STATUS, 32'h5);
      reg_wr(`LBT_REG_STATUS, 32'h4);
      rd_chk("status_clr", `LBT_REG_STATUS, 32'h1);
      chk_bit("log_ready", 1'h1, log_rdy);
      reg_wr(`LBT_REG_CTRL, 32'h2);
      @(posedge clk);
      dir <= 1'h0;
      cba <= 1'h0;
      far_bp <= 8'h77;
      settle(2);
      @(posedge clk);
      cba <= 1'h1;
      settle(2);
      rd_chk("log_ba", `LBT_REG_LOG, 32'h8000_0177);
      rd_chk("stored", `LBT_REG_STORED, 32'h0000_7744);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      #1;
      chk_bit("rst_bp_oe", 1'h0, bp_oe);
      chk_bit("rst_ready", 1'h0, log_rdy);
      @(posedge clk);
      rst_b <= 1'h1;
      t_wide_oe();
      t_single();
      t_transparent();
      t_latch();
      t_clocked();
      t_log();
      stop_test();
   end

   // The run needs well under a thousand cycles
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
endmodule

`default_nettype wire
